// ==== cdc_pkg.sv ====
package cdc_pkg;

    // byte addresses seen through the serial register pointer
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RESULT_ONE_HI = 8'h01;
    localparam logic [7:0] ADDR_RESULT_ONE_LO = 8'h02;
    localparam logic [7:0] ADDR_RESULT_TWO_HI = 8'h03;
    localparam logic [7:0] ADDR_RESULT_TWO_LO = 8'h04;
    localparam logic [7:0] ADDR_ZERO_ONE_HI = 8'h05;
    localparam logic [7:0] ADDR_ZERO_ONE_LO = 8'h06;
    localparam logic [7:0] ADDR_ZERO_TWO_HI = 8'h07;
    localparam logic [7:0] ADDR_ZERO_TWO_LO = 8'h08;
    localparam logic [7:0] ADDR_SCALE_ONE_HI = 8'h09;
    localparam logic [7:0] ADDR_SCALE_ONE_LO = 8'h0a;
    localparam logic [7:0] ADDR_SETUP_ONE = 8'h0b;
    localparam logic [7:0] ADDR_SCALE_TWO_HI = 8'h0c;
    localparam logic [7:0] ADDR_SCALE_TWO_LO = 8'h0d;
    localparam logic [7:0] ADDR_SETUP_TWO = 8'h0e;
    localparam logic [7:0] ADDR_CONTROL = 8'h0f;

    // reset values
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] ZERO_RESET = 16'h8000;
    localparam logic [15:0] SCALE_RESET = 16'h0000;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // code mapping
    localparam logic [15:0] DIFF_BASE = 16'h8000;
    localparam logic [15:0] SINGLE_BASE = 16'h3000;
    localparam logic [15:0] DIFF_MIDSCALE = 16'h8000;
    localparam logic [15:0] RESULT_MAX = 16'hfff0;
    localparam logic [16:0] GAIN_ONE = 17'h10000;
    localparam int GAIN_SHIFT = 16;
    localparam int RESULT_ZERO_BITS = 4;
    localparam logic [5:0] DIVIDE_STEPS = 6'h20;

    // status register bit positions
    localparam int STAT_POWER_DOWN_BIT = 7;
    localparam int STAT_LAST_CHANNEL_BIT = 2;
    localparam int STAT_SECOND_PENDING_BIT = 1;
    localparam int STAT_FIRST_PENDING_BIT = 0;

    // operating mode codes in the control register
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_CONTINUOUS = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h3;
    localparam logic [2:0] MODE_ZERO_CAL = 3'h5;
    localparam logic [2:0] MODE_SCALE_CAL = 3'h6;

    typedef struct packed {
        logic [1:0] range;
        logic differential_select;
        logic [4:0] unused;
    } input_setup_t;

    typedef struct packed {
        logic [2:0] unused;
        logic first_channel_on;
        logic second_channel_on;
        logic op_select_bit2;
        logic op_select_bit1;
        logic op_select_bit0;
    } op_control_t;

    typedef struct packed {
        logic [15:0] raw;
        logic [15:0] zero;
        logic [15:0] scale;
        logic differential_select;
    } scale_req_t;

endpackage

// ==== cdc_result_scaler.sv ====
`timescale 1ns/100ps
module cdc_result_scaler
    import cdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire scale_req_t req_i,
    output logic done_o,
    output logic [15:0] result_o
);
    logic [15:0] base;
    logic [15:0] mid;
    logic signed [17:0] span;
    logic signed [17:0] factor;
    logic signed [35:0] product;
    logic signed [20:0] sum;

    always_comb begin
        base = req_i.differential_select ? DIFF_BASE : SINGLE_BASE;
        mid = req_i.differential_select ? DIFF_MIDSCALE : 16'h0000;
        span = $signed({2'b00, req_i.raw}) - $signed({2'b00, req_i.zero}) + $signed({2'b00, base});
        factor = $signed({1'b0, GAIN_ONE + {1'b0, req_i.scale}});
        product = span * factor;
        sum = $signed({product[35], product[35:GAIN_SHIFT]}) + $signed({5'h00, mid});
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o <= 1'b0;
            result_o <= RESULT_RESET;
        end else begin
            done_o <= req_valid_i;
            if (req_valid_i) begin
                // clamp into the result span, low nibble forced clear
                if (sum < 0) begin
                    result_o <= 16'h0000;
                end else if (sum > $signed({5'h00, RESULT_MAX})) begin
                    result_o <= RESULT_MAX;
                end else begin
                    result_o <= {sum[15:RESULT_ZERO_BITS], 4'h0};
                end
            end
        end
    end
endmodule

// ==== cdc_result_calibration_control.sv ====
`timescale 1ns/100ps
// What this block does
// - results are 16-bit read-only; top 12 bits significant, low 4 bits read zero
// - results reset to zero and hold the latest scaled conversion per channel
// - raw full-scale span maps onto result span 0x0000 to 0xfff0
// - differential codes: negative, zero, positive; single-ended: zero, mid, full
// - differential result is (raw minus (offset minus 0x8000)) times gain plus 0x8000
// - single-ended result is (raw minus (offset minus 0x3000)) times gain
// - gain factor is (65536 plus gain coefficient) divided by 65536
// - finished conversion updates result unless a read of it is in progress
// - a read stays in progress until the bus stop condition
// - offset coefficients are 16-bit read/write and reset to 0x8000
// - offset set by offset calibration or by direct host write
// - each channel has its own offset and gain, calibrated independently
// - gain coefficients are read/write and start at the factory value
// - setup bits 7:6 pick the input range
// - setup bit 5 set means differential, clear means single-ended
// - setup registers reset to zero: single-ended, 2 pF range
// - control bits 4 and 3 enable channel one and channel two
// - control bits 2:0 select idle, continuous, single, power-down or calibrations
// - control register resets to zero: idle, both channels off
// - per-channel active-low pending flag is low while an unread result waits
// - status flag tells which channel converted last
module cdc_result_calibration_control
    import cdc_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic PTR_LOAD_I,
    input wire logic [7:0] PTR_VALUE_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    input wire logic BUS_STOP_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [15:0] FACTORY_SCALE_ONE_I,
    input wire logic [15:0] FACTORY_SCALE_TWO_I,
    input wire logic RAW_DONE_I,
    input wire logic [15:0] RAW_CODE_I,
    output logic CONV_START_O,
    output logic CONV_CHANNEL_O,
    output logic [1:0] CONV_RANGE_O,
    output logic CONV_DIFF_O,
    output logic POWER_DOWN_O,
    output logic FIRST_RESULT_PENDING_N_O,
    output logic SECOND_RESULT_PENDING_N_O,
    output logic LAST_CHANNEL_FLAG_O
);
    typedef enum logic [2:0] {S_IDLE, S_LAUNCH, S_WAIT_RAW, S_SCALE, S_DIVIDE, S_ADVANCE} seq_state_t;

    seq_state_t state;
    logic [7:0] ptr;
    logic host_wr;
    logic host_rd;
    op_control_t control;
    logic [2:0] mode;
    logic active;
    logic chan;
    logic gain_loaded;
    logic [15:0] result [2];
    logic [15:0] zero [2];
    logic [15:0] scale [2];
    input_setup_t setup [2];
    logic [1:0] pending_n;
    logic [1:0] read_busy;
    logic last_channel;

    logic result_wr;
    logic zero_cal_wr;
    logic scale_cal_wr;
    logic mode_clear;
    logic [15:0] zero_cal_value;
    logic [15:0] scale_cal_value;
    logic [15:0] chan_base;
    logic signed [17:0] cal_span;

    logic scale_req_valid;
    scale_req_t scale_req;
    logic scale_done;
    logic [15:0] scale_result;

    logic [5:0] div_count;
    logic [31:0] div_num;
    logic [32:0] div_rem;
    logic [31:0] div_quo;
    logic [17:0] div_den;
    logic [32:0] rem_shift;

    assign host_wr = REG_WR_I && !PTR_LOAD_I;
    assign host_rd = REG_RD_I && !PTR_LOAD_I && !REG_WR_I;
    assign mode = {control.op_select_bit2, control.op_select_bit1, control.op_select_bit0};

    always_comb begin
        active = 1'b0;
        case (mode)
            MODE_CONTINUOUS, MODE_SINGLE, MODE_ZERO_CAL, MODE_SCALE_CAL: begin
                active = control.first_channel_on || control.second_channel_on;
            end
            default: begin
                active = 1'b0;
            end
        endcase
    end

    // pointer auto-increments after every data byte so multi-byte reads stay coherent
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ptr <= ADDR_STATUS;
        end else if (PTR_LOAD_I) begin
            ptr <= PTR_VALUE_I;
        end else if (host_wr || host_rd) begin
            ptr <= ptr + 8'h01;
        end
    end

    // coefficient copy is taken one edge after reset release, never under reset
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gain_loaded <= 1'b0;
        end else begin
            gain_loaded <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            control <= CONTROL_RESET;
        end else if (host_wr && ptr == ADDR_CONTROL) begin
            control <= REG_WDATA_I;
        end else if (mode_clear) begin
            {control.op_select_bit2, control.op_select_bit1, control.op_select_bit0} <= MODE_IDLE;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            localparam logic [7:0] RES_HI = (g == 0) ? ADDR_RESULT_ONE_HI : ADDR_RESULT_TWO_HI;
            localparam logic [7:0] RES_LO = (g == 0) ? ADDR_RESULT_ONE_LO : ADDR_RESULT_TWO_LO;
            localparam logic [7:0] ZERO_HI = (g == 0) ? ADDR_ZERO_ONE_HI : ADDR_ZERO_TWO_HI;
            localparam logic [7:0] ZERO_LO = (g == 0) ? ADDR_ZERO_ONE_LO : ADDR_ZERO_TWO_LO;
            localparam logic [7:0] SCALE_HI = (g == 0) ? ADDR_SCALE_ONE_HI : ADDR_SCALE_TWO_HI;
            localparam logic [7:0] SCALE_LO = (g == 0) ? ADDR_SCALE_ONE_LO : ADDR_SCALE_TWO_LO;
            localparam logic [7:0] SETUP_AT = (g == 0) ? ADDR_SETUP_ONE : ADDR_SETUP_TWO;
            logic mine;
            logic result_hit;
            logic accept;

            assign mine = (chan == 1'(g));
            assign result_hit = host_rd && (ptr == RES_HI || ptr == RES_LO);
            // a conversion landing while the host reads this register is dropped
            assign accept = result_wr && mine && !read_busy[g] && !result_hit;

            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    read_busy[g] <= 1'b0;
                end else if (result_hit) begin
                    read_busy[g] <= 1'b1;
                end else if (BUS_STOP_I) begin
                    read_busy[g] <= 1'b0;
                end
            end

            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    result[g] <= RESULT_RESET;
                end else if (accept) begin
                    result[g] <= scale_result;
                end
            end

            // the read that clears the flag wins; a new result landing in that cycle is dropped
            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    pending_n[g] <= 1'b1;
                end else if (accept) begin
                    pending_n[g] <= 1'b0;
                end else if (result_hit) begin
                    pending_n[g] <= 1'b1;
                end
            end

            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    zero[g] <= ZERO_RESET;
                end else if (host_wr && ptr == ZERO_HI) begin
                    zero[g][15:8] <= REG_WDATA_I;
                end else if (host_wr && ptr == ZERO_LO) begin
                    zero[g][7:0] <= REG_WDATA_I;
                end else if (zero_cal_wr && mine) begin
                    zero[g] <= zero_cal_value;
                end
            end

            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    scale[g] <= SCALE_RESET;
                end else if (!gain_loaded) begin
                    scale[g] <= (g == 0) ? FACTORY_SCALE_ONE_I : FACTORY_SCALE_TWO_I;
                end else if (host_wr && ptr == SCALE_HI) begin
                    scale[g][15:8] <= REG_WDATA_I;
                end else if (host_wr && ptr == SCALE_LO) begin
                    scale[g][7:0] <= REG_WDATA_I;
                end else if (scale_cal_wr && mine) begin
                    scale[g] <= scale_cal_value;
                end
            end

            always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    setup[g] <= SETUP_RESET;
                end else if (host_wr && ptr == SETUP_AT) begin
                    setup[g] <= REG_WDATA_I;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (host_rd) begin
            case (ptr)
                ADDR_STATUS: begin
                    REG_RDATA_O <= 8'h00;
                    REG_RDATA_O[STAT_POWER_DOWN_BIT] <= (mode == MODE_POWER_DOWN);
                    REG_RDATA_O[STAT_LAST_CHANNEL_BIT] <= last_channel;
                    REG_RDATA_O[STAT_SECOND_PENDING_BIT] <= pending_n[1];
                    REG_RDATA_O[STAT_FIRST_PENDING_BIT] <= pending_n[0];
                end
                ADDR_RESULT_ONE_HI: REG_RDATA_O <= result[0][15:8];
                ADDR_RESULT_ONE_LO: REG_RDATA_O <= result[0][7:0];
                ADDR_RESULT_TWO_HI: REG_RDATA_O <= result[1][15:8];
                ADDR_RESULT_TWO_LO: REG_RDATA_O <= result[1][7:0];
                ADDR_ZERO_ONE_HI: REG_RDATA_O <= zero[0][15:8];
                ADDR_ZERO_ONE_LO: REG_RDATA_O <= zero[0][7:0];
                ADDR_ZERO_TWO_HI: REG_RDATA_O <= zero[1][15:8];
                ADDR_ZERO_TWO_LO: REG_RDATA_O <= zero[1][7:0];
                ADDR_SCALE_ONE_HI: REG_RDATA_O <= scale[0][15:8];
                ADDR_SCALE_ONE_LO: REG_RDATA_O <= scale[0][7:0];
                ADDR_SETUP_ONE: REG_RDATA_O <= setup[0];
                ADDR_SCALE_TWO_HI: REG_RDATA_O <= scale[1][15:8];
                ADDR_SCALE_TWO_LO: REG_RDATA_O <= scale[1][7:0];
                ADDR_SETUP_TWO: REG_RDATA_O <= setup[1];
                ADDR_CONTROL: REG_RDATA_O <= control;
                default: REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // calibration targets, taken from the raw code as it arrives
    always_comb begin
        chan_base = setup[chan].differential_select ? DIFF_BASE : SINGLE_BASE;
        zero_cal_value = RAW_CODE_I + chan_base;
        cal_span = $signed({2'b00, RAW_CODE_I}) - $signed({2'b00, zero[chan]}) + $signed({2'b00, chan_base});
        zero_cal_wr = (state == S_WAIT_RAW) && active && RAW_DONE_I && mode == MODE_ZERO_CAL;
        result_wr = (state == S_SCALE) && scale_done;
        scale_cal_wr = (state == S_DIVIDE) && div_count == 6'h00;
        mode_clear = (state == S_ADVANCE) && !(chan == 1'b0 && control.second_channel_on)
            && mode != MODE_CONTINUOUS;
        rem_shift = {div_rem[31:0], div_num[31]};
        if (div_quo < 32'h0001_0000) begin
            scale_cal_value = 16'h0000;
        end else if (div_quo >= 32'h0002_0000) begin
            scale_cal_value = 16'hffff;
        end else begin
            scale_cal_value = div_quo[15:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= S_IDLE;
            chan <= 1'b0;
            CONV_START_O <= 1'b0;
            scale_req_valid <= 1'b0;
            scale_req <= '0;
        end else begin
            CONV_START_O <= 1'b0;
            scale_req_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (active) begin
                        chan <= !control.first_channel_on;
                        state <= S_LAUNCH;
                    end
                end
                S_LAUNCH: begin
                    CONV_START_O <= 1'b1;
                    state <= S_WAIT_RAW;
                end
                S_WAIT_RAW: begin
                    if (!active) begin
                        state <= S_IDLE;
                    end else if (RAW_DONE_I) begin
                        case (mode)
                            MODE_ZERO_CAL: state <= S_ADVANCE;
                            MODE_SCALE_CAL: state <= (cal_span > 0) ? S_DIVIDE : S_ADVANCE;
                            default: begin
                                scale_req_valid <= 1'b1;
                                scale_req <= {RAW_CODE_I, zero[chan], scale[chan], setup[chan].differential_select};
                                state <= S_SCALE;
                            end
                        endcase
                    end
                end
                S_SCALE: begin
                    if (scale_done) begin
                        state <= S_ADVANCE;
                    end
                end
                S_DIVIDE: begin
                    if (div_count == 6'h00) begin
                        state <= S_ADVANCE;
                    end
                end
                S_ADVANCE: begin
                    if (chan == 1'b0 && control.second_channel_on) begin
                        chan <= 1'b1;
                        state <= S_LAUNCH;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // long division finds the factor that maps the full-scale span onto 0xfff0
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_count <= 6'h00;
            div_num <= 32'h0000_0000;
            div_rem <= 33'h0_0000_0000;
            div_quo <= 32'h0000_0000;
            div_den <= 18'h00000;
        end else if (state == S_WAIT_RAW && RAW_DONE_I && mode == MODE_SCALE_CAL) begin
            div_count <= DIVIDE_STEPS;
            div_num <= {(setup[chan].differential_select ? RESULT_MAX - DIFF_MIDSCALE : RESULT_MAX), 16'h0000};
            div_rem <= 33'h0_0000_0000;
            div_quo <= 32'h0000_0000;
            div_den <= cal_span;
        end else if (state == S_DIVIDE && div_count != 6'h00) begin
            div_count <= div_count - 6'h01;
            div_num <= {div_num[30:0], 1'b0};
            if (rem_shift >= {15'h0000, div_den}) begin
                div_rem <= rem_shift - {15'h0000, div_den};
                div_quo <= {div_quo[30:0], 1'b1};
            end else begin
                div_rem <= rem_shift;
                div_quo <= {div_quo[30:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            last_channel <= 1'b0;
        end else if (result_wr) begin
            last_channel <= chan;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            CONV_CHANNEL_O <= 1'b0;
            CONV_RANGE_O <= 2'h0;
            CONV_DIFF_O <= 1'b0;
            POWER_DOWN_O <= 1'b0;
        end else begin
            CONV_CHANNEL_O <= chan;
            CONV_RANGE_O <= setup[chan].range;
            CONV_DIFF_O <= setup[chan].differential_select;
            POWER_DOWN_O <= (mode == MODE_POWER_DOWN);
        end
    end

    assign FIRST_RESULT_PENDING_N_O = pending_n[0];
    assign SECOND_RESULT_PENDING_N_O = pending_n[1];
    assign LAST_CHANNEL_FLAG_O = last_channel;

    cdc_result_scaler u_scaler (
        .clk_i(CLK_SYS_I),
        .rst_b_i(RST_B_I),
        .req_valid_i(scale_req_valid),
        .req_i(scale_req),
        .done_o(scale_done),
        .result_o(scale_result)
    );
endmodule

// ==== conv_model.sv ====
`timescale 1ns/100ps
module conv_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [15:0] code_i,
    input wire logic [7:0] lat_i,
    output logic done_o,
    output logic [15:0] code_o
);
    // code is only meaningful with done; inverted otherwise so stale values never pass
    initial begin
        done_o = 0;
        code_o = 16'h0;
        forever begin
            @(posedge clk_i);
            if (start_i) begin
                repeat (lat_i) @(negedge clk_i);
                done_o = 1;
                code_o = code_i;
                @(negedge clk_i);
                done_o = 0;
                code_o = ~code_i;
            end
        end
    end
endmodule

// ==== cdc_checker.sv ====
`timescale 1ns/100ps
module cdc_checker (
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic PTR_LOAD_I,
    input wire logic [7:0] PTR_VALUE_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    input wire logic BUS_STOP_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic CONV_START_O,
    input wire logic CONV_CHANNEL_O,
    input wire logic POWER_DOWN_O,
    input wire logic FIRST_RESULT_PENDING_N_O
);
    logic [7:0] ptr;
    logic busy;
    wire rd = REG_RD_I && !PTR_LOAD_I && !REG_WR_I;
    wire wc = REG_WR_I && !PTR_LOAD_I && ptr == 8'h0f;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) ptr <= 8'h00;
        else if (PTR_LOAD_I) ptr <= PTR_VALUE_I;
        else if (REG_WR_I || REG_RD_I) ptr <= ptr + 8'h01;
    end
    // read of channel one result holds off updates until stop
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) busy <= 1'b0;
        else if (rd && (ptr == 8'h01 || ptr == 8'h02)) busy <= 1'b1;
        else if (BUS_STOP_I) busy <= 1'b0;
    end
    a_start_pulse: assert property (CONV_START_O |=> !CONV_START_O) else $error("start too long");
    a_power_quiet: assert property (POWER_DOWN_O |-> !CONV_START_O) else $error("start in power-down");
    a_low_zero: assert property (rd && (ptr == 8'h02 || ptr == 8'h04) |=> REG_RDATA_O[3:0] == 4'h0)
        else $error("result low bits set");
    a_read_clears: assert property (rd && ptr == 8'h01 |=> FIRST_RESULT_PENDING_N_O)
        else $error("pending kept");
    a_busy_holds: assert property (busy |=> FIRST_RESULT_PENDING_N_O) else $error("update during read");
    // write edge, then idle to launch, then the start pulse is seen at the third edge
    a_ctrl_start: assert property (wc && REG_WDATA_I[4]
        && REG_WDATA_I[2:0] inside {3'h1, 3'h2, 3'h5, 3'h6} |-> ##3 CONV_START_O && !CONV_CHANNEL_O)
        else $error("no start on channel one");
    a_no_enable: assert property (wc && REG_WDATA_I[4:3] == 2'h0 |-> !CONV_START_O [*3])
        else $error("start unenabled");
    a_power_level: assert property (wc && REG_WDATA_I[2:0] == 3'h3 |-> ##[1:2] POWER_DOWN_O)
        else $error("no pd");
    c_second: cover property (wc && REG_WDATA_I[3]);
    c_drop: cover property (busy && CONV_START_O);
    c_power: cover property (POWER_DOWN_O);
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rst_b = 0, pl = 0, wr = 0, rd = 0, stp = 0, done, st, ch, pd, p1, p2, lf, df;
    logic [7:0] pv = 8'h00, wd = 8'h00, rdat, lat = 8'h03;
    logic [15:0] raw, code = 16'h0, d;
    logic [1:0] rg;
    int err_count = 0, checks_done = 0, cyc = 0;
    logic [7:0] ra[8] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0e, 8'h0f};
    logic [15:0] re[8] = '{16'h0, 16'h0, 16'h8000, 16'h8000, 16'h1000, 16'h0, 16'h0, 16'h0};
    cdc_result_calibration_control DUT (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PTR_LOAD_I(pl), .PTR_VALUE_I(pv),
        .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RD_I(rd), .BUS_STOP_I(stp), .REG_RDATA_O(rdat),
        .FACTORY_SCALE_ONE_I(16'h1000), .FACTORY_SCALE_TWO_I(16'h0), .RAW_DONE_I(done), .RAW_CODE_I(raw),
        .CONV_START_O(st), .CONV_CHANNEL_O(ch), .CONV_RANGE_O(rg), .CONV_DIFF_O(df), .POWER_DOWN_O(pd),
        .FIRST_RESULT_PENDING_N_O(p1), .SECOND_RESULT_PENDING_N_O(p2), .LAST_CHANNEL_FLAG_O(lf));
    conv_model CM (.clk_i(clk), .start_i(st), .code_i(code), .lat_i(lat), .done_o(done), .code_o(raw));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cyc > 5000) begin
        err_count++;
        test_done();
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n); repeat (n) @(negedge clk); endtask
    task stop; stp = 1; tick(1); stp = 0; endtask
    task ptr(input logic [7:0] a); pl = 1; pv = a; tick(1); pl = 0; endtask
    task wrb(input logic [7:0] a, input logic [15:0] v, input int n);
        ptr(a); wr = 1;
        if (n == 2) begin wd = v[15:8]; tick(1); end
        wd = v[7:0]; tick(1); wr = 0; stop();
    endtask
    // hi byte first, one transaction; gap keeps the read open
    task rd16(input logic [7:0] a, input int gap, output logic [15:0] v);
        ptr(a); rd = 1; tick(1); rd = 0; v[15:8] = rdat; tick(gap + 1);
        rd = 1; tick(1); rd = 0; v[7:0] = rdat; stop();
    endtask
    task wait_p(input logic which);
        repeat (300) if ((which ? p2 : p1) !== 1'b0) tick(1);
    endtask
    function automatic logic [15:0] calc(input logic [15:0] r, z, g, input logic dif);
        longint s;
        s = longint'(r) - (longint'(z) - (dif ? 32'h8000 : 32'h3000));
        s = (s * (32'h10000 + longint'(g))) >>> 16;
        if (dif) s += 32'h8000;
        if (s < 0) s = 0;
        if (s > 32'hfff0) s = 32'hfff0;
        return 16'(s) & 16'hfff0;
    endfunction
    initial begin
        tick(2); rst_b = 1; tick(1);
        for (int i = 0; i < 8; i++) begin
            rd16(ra[i], 0, d); chk(d, re[i]);
        end
        $display("reset test done");
        wrb(8'h01, 16'hffff, 2); wrb(8'h05, 16'h3000, 2);
        wrb(8'h08, 16'h0012, 1); wrb(8'h0f, 16'h0002, 1);
        rd16(8'h01, 0, d); chk(d, 16'h0);
        rd16(8'h05, 0, d); chk(d, 16'h3000);
        rd16(8'h07, 0, d); chk(d, 16'h8012);
        $display("access test done");
        code = 16'h4000; wrb(8'h0f, 16'h0012, 1); wait_p(0); chk({15'h0, p1}, 16'h0);
        rd16(8'h01, 0, d); chk(d, calc(16'h4000, 16'h3000, 16'h1000, 0));
        chk({15'h0, p1}, 16'h1);
        rd16(8'h0f, 0, d); chk(d, 16'h1000);
        wrb(8'h0e, 16'h00e0, 1); code = 16'h9000; lat = 8'h14; wrb(8'h0f, 16'h001a, 1); wait_p(1);
        chk({15'h0, p2}, 16'h0);
        rd16(8'h01, 0, d); chk(d, calc(16'h9000, 16'h3000, 16'h1000, 0));
        rd16(8'h03, 0, d); chk(d, calc(16'h9000, 16'h8012, 16'h0, 1));
        chk({12'h0, lf, rg, df}, 16'h000f);
        $display("conversion test done");
        code = 16'h5000; lat = 8'h03; wrb(8'h0f, 16'h0011, 1); wait_p(0);
        fork
            rd16(8'h01, 40, d);
            begin tick(3); code = 16'h6000; end
        join
        chk(d, calc(16'h5000, 16'h3000, 16'h1000, 0));
        wait_p(0); rd16(8'h01, 0, d); chk(d, calc(16'h6000, 16'h3000, 16'h1000, 0));
        wrb(8'h0f, 16'h0010, 1); tick(5);
        $display("read hold test done");
        code = 16'h3100; wrb(8'h0f, 16'h0015, 1); tick(20);
        rd16(8'h05, 0, d); chk(d, 16'h6100);
        rd16(8'h0f, 0, d); chk(d, 16'h1000);
        code = 16'hb100; wrb(8'h0f, 16'h0016, 1); tick(60);
        rd16(8'h09, 0, d); chk(d, 16'hffe0);
        rd16(8'h07, 0, d); chk(d, 16'h8012);
        wrb(8'h0f, 16'h0013, 1); tick(2); chk({15'h0, pd}, 16'h1);
        wrb(8'h0f, 16'h0000, 1); tick(2); chk({15'h0, pd}, 16'h0);
        $display("calibration test done");
        test_done();
    end
endmodule
bind cdc_result_calibration_control cdc_checker CK (.*);
